/* File: rtl/flnc_pkg.sv */
// package for the flash lock and nonvolatile bit command unit
// assumes a 32-bit axi4-lite register bus and one clock domain
package flnc_pkg;
    localparam logic [31:0] off_mode = 32'h0000_0000;
    localparam logic [31:0] off_command = 32'h0000_0004;
    localparam logic [31:0] off_status = 32'h0000_0008;
    localparam logic [31:0] off_result = 32'h0000_000c;
    localparam logic [31:0] off_gp_control = 32'h0000_0010;
    localparam logic [31:0] mode_reset = 32'h0000_0000;
    localparam logic [7:0] protection_key = 8'h5a;
    localparam int key_lsb = 24;
    localparam int arg_lsb = 8;
    localparam int ready_bit = 0;
    localparam int cmd_error_bit = 1;
    localparam int lock_error_bit = 2;
    localparam int irq_enable_bit = 0;
    localparam int security_index = 0;
    localparam int trim8_lsb = 22;
    localparam int trim12_lsb = 32;
    localparam int trim_width = 7;
    localparam int word_bits = 32;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
    localparam real clock_mhz = 10.0;
    localparam real nvm_write_us = 1.0;
    localparam int nvm_write_cycles = int'(nvm_write_us * clock_mhz);
    localparam logic [7:0] set_lock_cmd = 8'h08;
    localparam logic [7:0] clear_lock_cmd = 8'h09;
    localparam logic [7:0] get_lock_cmd = 8'h0a;
    localparam logic [7:0] set_general_bit_cmd = 8'h0b;
    localparam logic [7:0] clear_general_bit_cmd = 8'h0c;
    localparam logic [7:0] get_general_bits_cmd = 8'h0d;
    localparam logic [7:0] start_identifier_cmd = 8'h0e;
    localparam logic [7:0] stop_identifier_cmd = 8'h0f;
    localparam logic [7:0] get_calibration_cmd = 8'h10;

    typedef enum logic [2:0] {
        flnc_src_none, flnc_src_lock, flnc_src_gp, flnc_src_calib
    } flnc_src_t;

    typedef struct packed {
        logic [7:0] code;
        logic [15:0] arg;
    } flnc_cmd_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } flnc_wreq_t;
endpackage

/* File: rtl/flnc_axil.sv */
// axi4-lite slave front end: captures one write and one read at a time
// assumes the core answers reads combinationally from its own registers
`timescale 1ns/100ps
module flnc_axil
    import flnc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_pulse,
    output flnc_pkg::flnc_wreq_t wr_req,
    input wire logic wr_ok,
    output logic rd_pulse,
    output logic [31:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    typedef struct packed {
        logic aw_have;
        logic w_have;
        logic [31:0] aw;
        logic [31:0] wd;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } flnc_axil_state_t;
    flnc_axil_state_t st, next_st;
    logic do_wr;

    assign awready = !st.aw_have && !st.bvalid;
    assign wready = !st.w_have && !st.bvalid;
    assign arready = !st.rvalid;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign rd_pulse = arvalid && arready;
    assign rd_addr = araddr;

    always_comb begin
        next_st = st;
        do_wr = 1'b0;
        wr_req.addr = st.aw_have ? st.aw : awaddr;
        wr_req.data = st.w_have ? st.wd : wdata;
        if (awvalid && awready) begin
            next_st.aw_have = 1'b1;
            next_st.aw = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_have = 1'b1;
            next_st.wd = wdata;
        end
        if ((st.aw_have || (awvalid && awready)) &&
            (st.w_have || (wvalid && wready))) begin
            do_wr = 1'b1;
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_ok ? resp_okay : resp_slverr;
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (rd_pulse) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_ok ? rd_data : 32'h0000_0000;
            next_st.rresp = rd_ok ? resp_okay : resp_slverr;
        end
    end
    assign wr_pulse = do_wr && (wstrb == wstrb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

/* File: rtl/flnc_nvm_cell.sv */
// nonvolatile bit array with a single-bit set/clear port
// assumes the array image survives only as long as its flops do
`timescale 1ns/100ps
module flnc_nvm_cell #(
    parameter int nbits = 8,
    parameter logic [nbits-1:0] init = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_en,
    input wire logic wr_val,
    input wire logic [15:0] wr_index,
    input wire logic clr_index0,
    output logic [nbits-1:0] bits
);
    typedef struct packed {
        logic [nbits-1:0] b;
    } flnc_cell_state_t;
    flnc_cell_state_t st, next_st;

    always_comb begin
        next_st = st;
        for (int i = 0; i < nbits; i++) begin
            if (wr_en && wr_index == 16'(i)) begin
                next_st.b[i] = wr_val;
            end
        end
        if (clr_index0) begin
            next_st.b[0] = 1'b0;
        end
    end
    assign bits = st.b;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '{b: init};
        end else begin
            st <= next_st;
        end
    end
endmodule

/* File: rtl/flnc_core.sv */
// flash lock / nonvolatile bit command unit, top level
// assumes the flash read path, erase engine and debug ports sit outside
// Function
// [RULE1] software writes set-lock with page number
// [RULE2] set-lock done raises ready, optional interrupt
// [RULE3] out-of-range lock number changes nothing
// [RULE4] only command error reported for these
// [RULE5] clear-lock unlocks region then ready
// [RULE6] get-lock ignores argument, fills result
// [RULE7] lock words lowest first, extra reads zero
// [RULE8] bit n set means region n locked
// [RULE9] flash reads continue during lock commands
// [RULE10] set general bit then ready, interrupt
// [RULE11] out-of-range general bit number ignored
// [RULE12] clear general bit then ready, interrupt
// [RULE13] get general bits in words, extras zero
// [RULE14] flash reads continue during general commands
// [RULE15] calibration bits read only, separate plane
// [RULE16] get calibration words lowest first, extras zero
// [RULE17] trims at bits 28:22 and 38:32
// [RULE18] security bit blocks debug and parallel access
// [RULE19] security cleared only by erase pin, full erase; the code also clears it with clear general bit on bit 0
// [RULE20] start identifier drops ready, maps identifier
// [RULE21] stop identifier restores map, raises ready
// [RULE22] software avoids running from flash meanwhile
// [RULE23] wrong key starts nothing, sets command error
// [RULE24] errors clear on status read, command write
// [RULE25] mode bit 0 enables ready interrupt
// [RULE26] result pointer restarts on accepted command
`timescale 1ns/100ps
module flnc_core
    import flnc_pkg::*;
#(
    parameter int lock_bits = 16,
    parameter int gp_bits = 2,
    parameter int calib_bits = 64,
    parameter logic [calib_bits-1:0] calib_value = '0,
    parameter int busy_cycles = nvm_write_cycles
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic erase_pin,
    input wire logic full_erase_done,
    output logic ready_irq,
    output logic identifier_mapped,
    output logic security_block,
    output logic flash_read_allowed,
    output logic [lock_bits-1:0] region_locked,
    output logic [6:0] trim_8mhz,
    output logic [6:0] trim_12mhz
);
    localparam int lock_words = (lock_bits + word_bits - 1) / word_bits;
    localparam int gp_words = (gp_bits + word_bits - 1) / word_bits;
    localparam int cal_words = (calib_bits + word_bits - 1) / word_bits;
    localparam int lock_pad = lock_words * word_bits;
    localparam int gp_pad = gp_words * word_bits;
    localparam int cal_pad = cal_words * word_bits;

    typedef enum logic [1:0] {
        st_idle, st_busy, st_ident
    } flnc_phase_t;

    typedef struct packed {
        logic [31:0] mode;
        logic ready;
        logic cmd_err;
        logic lock_err;
        flnc_phase_t phase;
        flnc_cmd_t cmd;
        logic [15:0] count;
        flnc_src_t src;
        logic [15:0] ptr;
        logic erase_armed;
        logic ready_q;
    } flnc_core_state_t;

    flnc_core_state_t st, next_st;
    logic wr_pulse;
    flnc_wreq_t wr_req;
    logic rd_pulse;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic wr_ok;
    logic lock_we;
    logic gp_we;
    logic nvm_val;
    logic sec_clear;
    logic [gp_bits-1:0] gp_state;
    logic [lock_pad-1:0] lock_flat;
    logic [gp_pad-1:0] gp_flat;
    logic [cal_pad-1:0] cal_flat;
    logic [31:0] result_word;
    logic cmd_write;
    logic key_ok;

    flnc_axil u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_pulse(wr_pulse),
        .wr_req(wr_req),
        .wr_ok(wr_ok),
        .rd_pulse(rd_pulse),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    flnc_nvm_cell #(.nbits(lock_bits)) u_lock (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(lock_we),
        .wr_val(nvm_val),
        .wr_index(st.cmd.arg),
        .clr_index0(1'b0),
        .bits(region_locked)
    );

    flnc_nvm_cell #(.nbits(gp_bits)) u_gp (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(gp_we),
        .wr_val(nvm_val),
        .wr_index(st.cmd.arg),
        .clr_index0(sec_clear),
        .bits(gp_state)
    );

    // zero-padded word images of each result source
    assign lock_flat = lock_pad'(region_locked); // RULE8
    assign gp_flat = gp_pad'(gp_state);
    assign cal_flat = cal_pad'(calib_value); // RULE15
    assign trim_8mhz = cal_flat[trim8_lsb +: trim_width]; // RULE17
    assign trim_12mhz = cal_flat[trim12_lsb +: trim_width]; // RULE17

    // result word by source and read pointer
    always_comb begin
        result_word = 32'h0000_0000;
        unique case (st.src)
            flnc_src_lock: begin
                if (st.ptr < 16'(lock_words)) begin
                    result_word = lock_flat[st.ptr*word_bits +: 32]; // RULE7
                end
            end
            flnc_src_gp: begin
                if (st.ptr < 16'(gp_words)) begin
                    result_word = gp_flat[st.ptr*word_bits +: 32]; // RULE13
                end
            end
            flnc_src_calib: begin
                if (st.ptr < 16'(cal_words)) begin
                    result_word = cal_flat[st.ptr*word_bits +: 32]; // RULE16
                end
            end
            default: result_word = 32'h0000_0000;
        endcase
    end

    // register read mux
    always_comb begin
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            off_mode: rd_data = st.mode;
            off_command: rd_data = 32'h0000_0000;
            off_status: begin
                rd_data[ready_bit] = st.ready;
                rd_data[cmd_error_bit] = st.cmd_err;
                rd_data[lock_error_bit] = st.lock_err;
            end
            off_result: rd_data = result_word;
            off_gp_control: rd_data = 32'(gp_state);
            default: rd_ok = 1'b0;
        endcase
    end

    assign wr_ok = wr_req.addr == off_mode ||
        wr_req.addr == off_command || wr_req.addr == off_status ||
        wr_req.addr == off_result || wr_req.addr == off_gp_control;
    assign cmd_write = wr_pulse && wr_req.addr == off_command;
    assign key_ok = wr_req.data[key_lsb +: 8] == protection_key; // RULE23

    // completion of a write-type command updates the nvm arrays
    always_comb begin
        lock_we = 1'b0;
        gp_we = 1'b0;
        nvm_val = 1'b0;
        if (st.phase == st_busy && st.count == 16'h0000) begin
            unique case (st.cmd.code)
                set_lock_cmd: begin
                    lock_we = st.cmd.arg < 16'(lock_bits); // RULE1 RULE3
                    nvm_val = 1'b1;
                end
                clear_lock_cmd: begin
                    lock_we = st.cmd.arg < 16'(lock_bits); // RULE5 RULE3
                end
                set_general_bit_cmd: begin
                    gp_we = st.cmd.arg < 16'(gp_bits); // RULE10 RULE11
                    nvm_val = 1'b1;
                end
                clear_general_bit_cmd: begin
                    gp_we = st.cmd.arg < 16'(gp_bits); // RULE12 RULE11
                end
                default: nvm_val = 1'b0;
            endcase
        end
    end

    // security bit: erase pin plus full erase clears it, as does clear general bit with argument 0
    assign sec_clear = st.erase_armed && full_erase_done; // RULE19

    always_comb begin
        next_st = st;
        next_st.ready_q = st.ready;
        next_st.erase_armed = erase_pin;
        if (rd_pulse && rd_addr == off_status) begin
            next_st.cmd_err = 1'b0; // RULE24
            next_st.lock_err = 1'b0;
        end
        if (rd_pulse && rd_addr == off_result) begin
            next_st.ptr = st.ptr + 16'h0001; // RULE7
        end
        if (wr_pulse && wr_req.addr == off_mode) begin
            next_st.mode = wr_req.data;
        end
        if (st.phase == st_busy) begin
            if (st.count != 16'h0000) begin
                next_st.count = st.count - 16'h0001;
            end else if (st.cmd.code == start_identifier_cmd) begin
                next_st.phase = st_ident; // RULE20
            end else begin
                next_st.phase = st_idle;
                next_st.ready = 1'b1; // RULE2 RULE10 RULE12 RULE21
            end
        end
        if (cmd_write) begin
            next_st.cmd_err = 1'b0; // RULE24
            next_st.lock_err = 1'b0;
            if (!key_ok) begin
                next_st.cmd_err = 1'b1; // RULE23 RULE4
            end else if (st.phase == st_idle ||
                (st.phase == st_ident &&
                wr_req.data[7:0] == stop_identifier_cmd)) begin
                next_st.cmd.code = wr_req.data[7:0];
                next_st.cmd.arg = wr_req.data[arg_lsb +: 16];
                next_st.ptr = 16'h0000; // RULE26
                next_st.phase = st_busy;
                next_st.ready = 1'b0;
                next_st.count = 16'(busy_cycles);
                unique case (wr_req.data[7:0])
                    get_lock_cmd: next_st.src = flnc_src_lock; // RULE6
                    get_general_bits_cmd: next_st.src = flnc_src_gp;
                    get_calibration_cmd: next_st.src = flnc_src_calib;
                    set_lock_cmd, clear_lock_cmd, set_general_bit_cmd,
                    clear_general_bit_cmd, start_identifier_cmd,
                    stop_identifier_cmd: next_st.src = flnc_src_none;
                    default: begin
                        next_st.cmd_err = 1'b1;
                        next_st.phase = st.phase;
                        next_st.ready = st.ready;
                        next_st.cmd = st.cmd;
                        next_st.ptr = st.ptr;
                        next_st.count = st.count;
                    end
                endcase
            end else begin
                next_st.cmd_err = 1'b1;
            end
        end
    end

    assign ready_irq = st.mode[irq_enable_bit] && st.ready; // RULE25
    assign identifier_mapped = st.phase == st_ident; // RULE20
    assign security_block = gp_state[security_index]; // RULE18
    assign flash_read_allowed = st.phase != st_ident; // RULE9 RULE14 RULE22

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '{mode: mode_reset, ready: 1'b1, phase: st_idle,
                src: flnc_src_none, default: '0};
        end else begin
            st <= next_st;
        end
    end
endmodule

/* File: verif/flnc_core_chk.sv */
// assertion checker for the command unit bus and status outputs
// assumes bind onto flnc_core with matching parameters
`timescale 1ns/100ps
module flnc_core_chk #(
    parameter int lock_bits = 16,
    parameter int calib_bits = 64,
    parameter logic [calib_bits-1:0] calib_value = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic ready_irq,
    input wire logic identifier_mapped,
    input wire logic flash_read_allowed,
    input wire logic [lock_bits-1:0] region_locked,
    input wire logic [6:0] trim_8mhz,
    input wire logic [6:0] trim_12mhz
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_map;
        flash_read_allowed != identifier_mapped;
    endproperty
    a_map: assert property (p_map)
        else $error("read path state wrong");
    property p_idrdy;
        identifier_mapped |-> !ready_irq;
    endproperty
    a_idrdy: assert property (p_idrdy)
        else $error("ready seen in identifier mode");
    property p_trim;
        trim_8mhz == calib_value[28:22] && trim_12mhz == calib_value[38:32];
    endproperty
    a_trim: assert property (p_trim)
        else $error("trim value wrong");
    property p_lock;
        $changed(region_locked) |->
            $onehot(region_locked ^ $past(region_locked));
    endproperty
    a_lock: assert property (p_lock)
        else $error("more than one lock bit changed");
    property p_bone;
        bvalid && bready |=> !bvalid;
    endproperty
    a_bone: assert property (p_bone)
        else $error("extra write response");
    property p_rone;
        rvalid && rready |=> !rvalid;
    endproperty
    a_rone: assert property (p_rone)
        else $error("extra read response");
    property p_rans;
        arvalid && arready |=> rvalid;
    endproperty
    a_rans: assert property (p_rans)
        else $error("read answer late");
    property p_wref;
        bvalid |-> !awready && !wready;
    endproperty
    a_wref: assert property (p_wref)
        else $error("write taken during response");
endmodule

/* File: verif/flnc_erase_model.sv */
// erase pin and full-erase model standing for the flash macro
// assumes a one-cycle go request from the bench
`timescale 1ns/100ps
module flnc_erase_model #(
    parameter int erase_cycles = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    output logic erase_pin,
    output logic full_erase_done
);
    logic [7:0] cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= '0;
            erase_pin <= 1'b0;
            full_erase_done <= 1'b0;
        end else begin
            full_erase_done <= 1'b0;
            if (go) begin
                erase_pin <= 1'b1;
                cnt <= 8'(erase_cycles);
            end else if (cnt > 8'h1) begin
                cnt <= cnt - 8'h1;
            end else if (cnt == 8'h1) begin
                cnt <= '0;
                full_erase_done <= 1'b1;
            end else begin
                erase_pin <= 1'b0;
            end
        end
    end
endmodule

/* File: verif/flnc_core_tb.sv */
// self-checking bench for the lock and nonvolatile bit command unit
// assumes the erase model on the erase inputs and the bound checker
`timescale 1ns/100ps
module flnc_core_tb;
    import flnc_pkg::*;
    localparam logic [63:0] cal = {25'h0, 7'h5a, 3'h0, 7'h2b, 22'h0};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic erase_go = 1'b0;
    logic bready = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, erase_pin, erase_done;
    logic ready_irq, id_map, sec_blk, rd_ok;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] locked;
    logic [6:0] trim8, trim12;
    int err_total = 0;
    int checked = 0;

    initial forever #50 aclk = ~aclk;

    flnc_core #(.lock_bits(16), .gp_bits(2), .calib_bits(64),
        .calib_value(cal), .busy_cycles(4)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .erase_pin(erase_pin), .full_erase_done(erase_done),
        .ready_irq(ready_irq), .identifier_mapped(id_map),
        .security_block(sec_blk), .flash_read_allowed(rd_ok),
        .region_locked(locked), .trim_8mhz(trim8), .trim_12mhz(trim12));

    flnc_erase_model u_erase (.aclk(aclk), .aresetn(aresetn),
        .go(erase_go), .erase_pin(erase_pin),
        .full_erase_done(erase_done));

    task automatic end_sim;
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            bready <= !tb;
        end
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            rready <= !tr;
        end
    endtask

    task automatic rchk(input string n, input logic [31:0] a,
        input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(n, e, d);
    endtask

    task automatic cmd(input logic [7:0] c, input logic [15:0] g);
        wr(off_command, {protection_key, g, c});
    endtask

    task automatic run(input logic [7:0] c, input logic [15:0] g);
        logic [31:0] d;
        logic [1:0] r;
        cmd(c, g);
        d = '0;
        while (d[0] !== 1'b1) rd(off_status, d, r);
    endtask

    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        end_sim();
    end

    initial begin : main
        logic [31:0] d;
        logic [1:0] r;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk("mode", off_mode, mode_reset);
        rchk("status", off_status, 32'h1);
        rchk("result", off_result, 32'h0);
        rd(32'h14, d, r);
        chk("unmapped", 32'h0, d);
        chk("unmapped resp", {30'h0, resp_slverr}, {30'h0, r});
        wr(off_mode, 32'h1);
        rchk("mode", off_mode, 32'h1);
        cmd(set_lock_cmd, 16'h3);
        @(negedge aclk);
        chk("irq busy", 32'h0, {31'h0, ready_irq});
        chk("read open", 32'h1, {31'h0, rd_ok});
        @(posedge aclk);
        d = '0;
        while (d[0] !== 1'b1) rd(off_status, d, r);
        @(negedge aclk);
        chk("irq done", 32'h1, {31'h0, ready_irq});
        @(posedge aclk);
        run(set_lock_cmd, 16'h5);
        run(set_lock_cmd, 16'h10);
        run(clear_lock_cmd, 16'h3);
        run(get_lock_cmd, 16'hffff);
        rchk("lock w0", off_result, 32'h20);
        rchk("lock w1", off_result, 32'h0);
        chk("locked", 32'h20, {16'h0, locked});
        run(set_general_bit_cmd, 16'h1);
        run(set_general_bit_cmd, 16'h2);
        run(get_general_bits_cmd, 16'h7);
        rchk("gp w0", off_result, 32'h2);
        rchk("gp w1", off_result, 32'h0);
        run(set_general_bit_cmd, 16'h0);
        run(clear_general_bit_cmd, 16'h1);
        run(clear_general_bit_cmd, 16'h9);
        run(get_general_bits_cmd, 16'h0);
        rchk("gp w0", off_result, 32'h1);
        rchk("gp reg", off_gp_control, 32'h1);
        @(negedge aclk);
        chk("secure", 32'h1, {31'h0, sec_blk});
        @(posedge aclk);
        erase_go <= 1'b1;
        @(posedge aclk);
        erase_go <= 1'b0;
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        chk("unsecure", 32'h0, {31'h0, sec_blk});
        @(posedge aclk);
        run(get_calibration_cmd, 16'h5);
        rchk("cal w0", off_result, cal[31:0]);
        rchk("cal w1", off_result, cal[63:32]);
        rchk("cal w2", off_result, 32'h0);
        wr(off_command, {8'h5b, 16'h1, set_lock_cmd});
        rchk("bad key", off_status, 32'h3);
        rchk("err clr", off_status, 32'h1);
        wr(off_command, {protection_key, 16'h0, 8'h07});
        cmd(get_lock_cmd, 16'h0);
        rchk("err on cmd", off_status, 32'h0);
        d = '0;
        while (d[0] !== 1'b1) rd(off_status, d, r);
        rchk("lock w0", off_result, 32'h20);
        run(get_lock_cmd, 16'h0);
        rchk("lock kept", off_result, 32'h20);
        cmd(start_identifier_cmd, 16'h0);
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        chk("mapped", 32'h1, {31'h0, id_map});
        chk("read shut", 32'h0, {31'h0, rd_ok});
        @(posedge aclk);
        rchk("id status", off_status, 32'h0);
        run(stop_identifier_cmd, 16'h0);
        @(negedge aclk);
        chk("unmap", 32'h0, {31'h0, id_map});
        chk("irq stop", 32'h1, {31'h0, ready_irq});
        @(posedge aclk);
        end_sim();
    end
endmodule

bind flnc_core flnc_core_chk #(.lock_bits(lock_bits),
    .calib_bits(calib_bits), .calib_value(calib_value)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready),
    .ready_irq(ready_irq), .identifier_mapped(identifier_mapped),
    .flash_read_allowed(flash_read_allowed),
    .region_locked(region_locked), .trim_8mhz(trim_8mhz),
    .trim_12mhz(trim_12mhz));
